//--- verilog/psf_regs.svh
// register map, field positions and timing figures of the psi5 framer
`ifndef PSF_REGS_SVH
`define PSF_REGS_SVH
// ---------------------------------------------------------------
// register byte addresses
// ---------------------------------------------------------------
`define PSF_ADDR_CFG  8'h00
`define PSF_ADDR_STS  8'h04
`define PSF_ADDR_MSK  8'h08
`define PSF_ADDR_LAST 8'h0c
`define PSF_CFG_RST   16'h0001
// ---------------------------------------------------------------
// link_format_config fields
// ---------------------------------------------------------------
`define PSF_B_CHAN  15
`define PSF_B_PAR   14
`define PSF_B_SYNC  13
`define PSF_B_BAUD  12
`define PSF_B_STEN  10
`define PSF_B_ERRST 9
`define PSF_B_THIRD 8
`define PSF_F_PER   7:6
`define PSF_F_K     5:4
`define PSF_F_SIZE  3:0
// ---------------------------------------------------------------
// timing and frame constants
// ---------------------------------------------------------------
`define PSF_CLK_MHZ 250
`define PSF_KBPS_LO 125
`define PSF_KBPS_HI 189
`define PSF_BITCYC(k) (`PSF_CLK_MHZ * 1000 / (k))
`define PSF_PER0_US 1000
`define PSF_PER1_US 500
`define PSF_PER2_US 300
`define PSF_PER3_US 250
`define PSF_DEFECT  10'h1f4
`define PSF_READY   10'h1e7
`define PSF_BASE_W  9
`define PSF_INIT_W  10
`define PSF_START_N 2
`define PSF_FC_N    3
`define PSF_CRC_N   3
`define PSF_CRC_SEED 3'h7
`define PSF_FC_POS  3'h1
`define PSF_FC_SPD  3'h2
`define PSF_I_DONE  0
`define PSF_I_DEF   1
`define PSF_I_OVR   2
`define PSF_OKAY    2'h0
`define PSF_SLVERR  2'h2
`endif

//--- verilog/psf_pkg.sv
// types of the psi5 framer
package psf_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SEND = 3'b010,
        ST_GAP  = 3'b100
    } psf_state_e;

    typedef struct packed {
        logic [5:0]  len;
        logic [23:0] data;
        logic [31:0] vec;
    } psf_frame_s;

    typedef struct packed {
        psf_state_e  st;
        logic [15:0] cfg;
        logic [2:0]  sts;
        logic [2:0]  msk;
        logic [11:0] baud;
        logic [5:0]  idx;
        logic [5:0]  len;
        logic [31:0] vec;
        logic [2:0]  crc;
        logic        par;
        logic [1:0]  slot;
        logic [17:0] per;
        logic        tx;
        logic        act;
        logic [23:0] last;
        logic        aw_got;
        logic        w_got;
        logic [7:0]  aw_addr;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } psf_state_s;
endpackage : psf_pkg

//--- verilog/psf_framer.sv
// psi5 frame builder with fault reporting and axi4-lite configuration
//
// The AXI4-Lite register port and the placing of the registers were left to the implementer.
`include "psf_regs.svh"

module psf_framer
    import psf_pkg::*;
#(
    parameter int P_PER0_CYC = `PSF_PER0_US * `PSF_CLK_MHZ,
    parameter int P_PER1_CYC = `PSF_PER1_US * `PSF_CLK_MHZ,
    parameter int P_PER2_CYC = `PSF_PER2_US * `PSF_CLK_MHZ,
    parameter int P_PER3_CYC = `PSF_PER3_US * `PSF_CLK_MHZ
) (
    // clock and reset
    input  wire logic        i_mclk,
    input  wire logic        i_rst,
    // axi4-lite write channels
    input  wire logic        i_awvalid,
    output logic             o_awready,
    input  wire logic [7:0]  i_awaddr,
    input  wire logic        i_wvalid,
    output logic             o_wready,
    input  wire logic [31:0] i_wdata,
    input  wire logic [3:0]  i_wstrb,
    output logic             o_bvalid,
    input  wire logic        i_bready,
    output logic [1:0]       o_bresp,
    // axi4-lite read channels
    input  wire logic        i_arvalid,
    output logic             o_arready,
    input  wire logic [7:0]  i_araddr,
    output logic             o_rvalid,
    input  wire logic        i_rready,
    output logic [31:0]      o_rdata,
    output logic [1:0]       o_rresp,
    // sensor side
    input  wire logic        i_sync,
    input  wire logic [23:0] i_position,
    input  wire logic [23:0] i_speed,
    input  wire logic        i_defect,
    input  wire logic [5:0]  i_diag,
    input  wire logic        i_init_ph3,
    // line side and events
    output logic             o_tx_data,
    output logic             o_tx_active,
    output logic [2:0]       o_nibble_reps,
    output logic             o_irq
);

    // ---------------------------------------------------------------
    // timing counts
    // ---------------------------------------------------------------
    // bit times round down so a frame never overruns its slot
    localparam logic [11:0] BIT_LO = 12'(`PSF_BITCYC(`PSF_KBPS_LO));
    localparam logic [11:0] BIT_HI = 12'(`PSF_BITCYC(`PSF_KBPS_HI));

    psf_state_s r;
    psf_state_s n;
    psf_frame_s f;
    logic       ld;
    logic       trig;
    logic [1:0] ld_slot;
    logic [11:0] bitc;
    logic [17:0] perc;
    logic [2:0] ev;
    logic [2:0] clr;
    logic       b;
    logic [2:0] crc_n;
    logic       par_n;
    logic [5:0] nidx;
    logic [5:0] ck_n;
    logic [1:0] nslots;

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    // slot carries speed in two- or three-slot layouts
    function automatic logic speed_slot(input logic [15:0] c, input logic [1:0] s);
        return c[`PSF_B_CHAN] &&
               (c[`PSF_B_THIRD] ? (s == 2'h2) : (s == 2'h1));
    endfunction : speed_slot

    // assemble one frame in transmit order, bit 0 first
    function automatic psf_frame_s build_frame(
        input logic [15:0] c,
        input logic        sp,
        input logic        ph3,
        input logic        dft,
        input logic [5:0]  dg,
        input logic [23:0] pv,
        input logic [23:0] sv
    );
        psf_frame_s fr;
        logic [2:0]  fc;
        logic [23:0] d24;
        logic        stb;
        int          w;
        int          k;
        fr = '0;
        k = `PSF_START_N;
        fc = sp ? `PSF_FC_SPD : `PSF_FC_POS;
        for (int i = 0; i < `PSF_FC_N; i++) begin
            fr.vec[k + i] = fc[i];
        end
        k = k + `PSF_FC_N;
        // init phase three always flags errors in the status bit
        stb = ph3 ? dft : (c[`PSF_B_ERRST] & dft);
        if (ph3 || c[`PSF_B_STEN]) begin
            fr.vec[k] = stb;
            k = k + 1;
        end
        w = ph3 ? `PSF_INIT_W : `PSF_BASE_W + int'(c[`PSF_F_SIZE]);
        // code at the top, flags below it; shifting drops the memory end
        d24 = {`PSF_DEFECT, dg, 8'h00};
        if (ph3) begin
            fr.data = {14'h0, dft ? `PSF_DEFECT : `PSF_READY};
        end else if (dft) begin
            fr.data = d24 >> (24 - w);
        end else begin
            fr.data = sp ? sv : pv;
        end
        // data region goes out lsb first
        for (int i = 0; i < 24; i++) begin
            if (i < w) begin
                fr.vec[k + i] = fr.data[i];
            end else begin
                fr.data[i] = 1'b0;
            end
        end
        fr.len = 6'(k + w);
        return fr;
    endfunction : build_frame

    // ---------------------------------------------------------------
    // combinational next state
    // ---------------------------------------------------------------
    always_comb begin
        n = r;
        ev = 3'h0;
        clr = 3'h0;
        trig = 1'b0;
        ld = 1'b0;
        b = 1'b0;
        crc_n = r.crc;
        par_n = r.par;
        nidx = r.idx + 6'h1;
        ck_n = r.cfg[`PSF_B_PAR] ? 6'h1 : 6'(`PSF_CRC_N);
        nslots = r.cfg[`PSF_B_CHAN] ? (r.cfg[`PSF_B_THIRD] ? 2'h3 : 2'h2) : 2'h1;
        bitc = r.cfg[`PSF_B_BAUD] ? BIT_HI : BIT_LO;
        case (r.cfg[`PSF_F_PER])
            2'h0: perc = 18'(P_PER0_CYC);
            2'h1: perc = 18'(P_PER1_CYC);
            2'h2: perc = 18'(P_PER2_CYC);
            default: perc = 18'(P_PER3_CYC);
        endcase
        // trigger: ecu pulse or free-running period counter
        if (r.cfg[`PSF_B_SYNC]) begin
            trig = i_sync;
            n.per = 18'h0;
        end else if (r.per == 18'h0) begin
            trig = 1'b1;
            n.per = perc - 18'h1;
        end else begin
            n.per = r.per - 18'h1;
        end
        if (trig && (r.st != ST_IDLE)) begin
            ev[`PSF_I_OVR] = 1'b1;
        end
        ld_slot = (r.st == ST_IDLE) ? 2'h0 : r.slot + 2'h1;
        f = build_frame(r.cfg, speed_slot(r.cfg, ld_slot), i_init_ph3,
                        i_defect, i_diag, i_position, i_speed);
        // frame sequencer
        case (r.st)
            ST_IDLE: begin
                ld = trig;
            end
            ST_SEND: begin
                if (r.baud == bitc - 12'h1) begin
                    n.baud = 12'h0;
                    b = r.vec[r.idx[4:0]];
                    // checksum covers every bit between the start bits and the checksum
                    if (r.idx < r.len && r.idx >= 6'(`PSF_START_N)) begin
                        crc_n = {r.crc[1], r.crc[0] ^ b ^ r.crc[2], b ^ r.crc[2]};
                        par_n = r.par ^ b;
                    end
                    n.crc = crc_n;
                    n.par = par_n;
                    n.idx = nidx;
                    if (nidx < r.len) begin
                        n.tx = r.vec[nidx[4:0]];
                    end else if (nidx < r.len + ck_n) begin
                        n.tx = r.cfg[`PSF_B_PAR] ? par_n
                             : crc_n[2'(6'h2 - (nidx - r.len))];
                    end else begin
                        n.tx = 1'b0;
                        n.act = 1'b0;
                        if (2'(r.slot + 2'h1) < nslots) begin
                            n.st = ST_GAP;
                        end else begin
                            n.st = ST_IDLE;
                            ev[`PSF_I_DONE] = 1'b1;
                        end
                    end
                end else begin
                    n.baud = r.baud + 12'h1;
                end
            end
            ST_GAP: begin
                // one idle bit time between slots of a cycle
                if (r.baud == bitc - 12'h1) begin
                    ld = 1'b1;
                end else begin
                    n.baud = r.baud + 12'h1;
                end
            end
            default: begin
                n.st = ST_IDLE;
            end
        endcase
        if (ld) begin
            n.st = ST_SEND;
            n.slot = ld_slot;
            n.vec = f.vec;
            n.len = f.len;
            n.last = f.data;
            n.idx = 6'h0;
            n.baud = 12'h0;
            n.tx = f.vec[0];
            n.act = 1'b1;
            n.crc = `PSF_CRC_SEED;
            n.par = 1'b0;
            ev[`PSF_I_DEF] = i_defect;
        end

        // ---------------------------------------------------------------
        // axi4-lite slave
        // ---------------------------------------------------------------
        if (i_awvalid && o_awready) begin
            n.aw_got = 1'b1;
            n.aw_addr = i_awaddr;
        end
        if (i_wvalid && o_wready) begin
            n.w_got = 1'b1;
            n.wdata = i_wdata;
            n.wstrb = i_wstrb;
        end
        if (r.bvalid && i_bready) begin
            n.bvalid = 1'b0;
        end
        // write commits one cycle after both halves are held
        if (r.aw_got && r.w_got) begin
            n.aw_got = 1'b0;
            n.w_got = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = `PSF_OKAY;
            case (r.aw_addr)
                `PSF_ADDR_CFG: begin
                    if (r.wstrb[0]) n.cfg[7:0] = r.wdata[7:0];
                    if (r.wstrb[1]) n.cfg[15:8] = r.wdata[15:8];
                end
                `PSF_ADDR_MSK: begin
                    if (r.wstrb[0]) n.msk = r.wdata[2:0];
                end
                `PSF_ADDR_STS, `PSF_ADDR_LAST: begin
                    n.bresp = `PSF_OKAY;
                end
                default: begin
                    n.bresp = `PSF_SLVERR;
                end
            endcase
        end
        if (r.rvalid && i_rready) begin
            n.rvalid = 1'b0;
        end
        if (i_arvalid && o_arready) begin
            n.rvalid = 1'b1;
            n.rresp = `PSF_OKAY;
            case (i_araddr)
                `PSF_ADDR_CFG:  n.rdata = {16'h0, r.cfg};
                `PSF_ADDR_STS: begin
                    n.rdata = {29'h0, r.sts};
                    clr = r.sts;
                end
                `PSF_ADDR_MSK:  n.rdata = {29'h0, r.msk};
                `PSF_ADDR_LAST: n.rdata = {8'h0, r.last};
                default: begin
                    n.rdata = 32'h0;
                    n.rresp = `PSF_SLVERR;
                end
            endcase
        end
        // an event in the clearing cycle survives the read
        n.sts = (r.sts & ~clr) | ev;
    end

    // ---------------------------------------------------------------
    // state register
    // ---------------------------------------------------------------
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            r <= '0;
            r.st <= ST_IDLE;
            r.cfg <= `PSF_CFG_RST;
        end else begin
            r <= n;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign o_awready = !r.aw_got && !r.bvalid;
    assign o_wready = !r.w_got && !r.bvalid;
    assign o_arready = !r.rvalid;
    assign o_bvalid = r.bvalid;
    assign o_bresp = r.bresp;
    assign o_rvalid = r.rvalid;
    assign o_rdata = r.rdata;
    assign o_rresp = r.rresp;
    assign o_tx_data = r.tx;
    assign o_tx_active = r.act;
    assign o_nibble_reps = {1'b0, r.cfg[`PSF_F_K]} + 3'h1;
    assign o_irq = |(r.sts & r.msk);

    // ---------------------------------------------------------------
    // assertions and cover
    // ---------------------------------------------------------------
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (i_rst);

    a_defect_code_ten: assert property (
        ld && i_defect && !i_init_ph3 && r.cfg[`PSF_F_SIZE] == 4'h1
        |=> r.last == {14'h0, `PSF_DEFECT})
        else $error("ten-bit defect frame lacks the defect code");
    a_diag_sixteen: assert property (
        ld && i_defect && !i_init_ph3 && r.cfg[`PSF_F_SIZE] == 4'h7
        |=> r.last == {8'h0, `PSF_DEFECT, $past(i_diag)})
        else $error("sixteen-bit defect frame diagnosis misplaced");
    a_diag_eleven: assert property (
        ld && i_defect && !i_init_ph3 && r.cfg[`PSF_F_SIZE] == 4'h2
        |=> r.last == {13'h0, `PSF_DEFECT, $past(i_diag[5])})
        else $error("eleven-bit defect frame diagnosis wrong");
    a_no_status_len: assert property (
        ld && !i_init_ph3 && !r.cfg[`PSF_B_STEN]
        |=> r.len == 6'(5 + `PSF_BASE_W) + 6'($past(r.cfg[`PSF_F_SIZE])))
        else $error("frame length wrong without status bit");
    a_init_ph3_word: assert property (
        ld && i_init_ph3 && i_defect
        |=> r.last == {14'h0, `PSF_DEFECT} && r.len == 6'h10)
        else $error("phase three defect word or length wrong");
    a_sync_start: assert property (
        r.cfg[`PSF_B_SYNC] && i_sync && r.st == ST_IDLE
        |=> r.st == ST_SEND ##1 r.st == ST_SEND)
        else $error("trigger pulse did not start a frame");
    a_async_wait: assert property (
        !r.cfg[`PSF_B_SYNC] && r.st == ST_IDLE && r.per != 18'h0
        |=> r.st == ST_IDLE)
        else $error("free-running frame started before its period");
    a_fast_bit: assert property (
        r.st == ST_SEND && r.cfg[`PSF_B_BAUD] |-> r.baud < BIT_HI)
        else $error("bit time exceeds the fast rate");
    a_start_zero: assert property (
        $rose(o_tx_active) |-> !o_tx_data [*2])
        else $error("frame does not open with a zero start bit");
    a_irq_level: assert property (
        trig && r.st != ST_IDLE && r.msk[`PSF_I_OVR] |=> o_irq || !r.msk[`PSF_I_OVR])
        else $error("unmasked overrun did not raise the interrupt");

    c_sync_frame: cover property (r.cfg[`PSF_B_SYNC] && ld);
    c_defect_frame: cover property (ld && i_defect && !i_init_ph3);
    c_third_slot: cover property (ld && ld_slot == 2'h2);
    c_irq: cover property ($rose(o_irq));

endmodule : psf_framer

//--- tb/psf_ecu_rx.sv
// behavioural ecu receiver that samples the framer's line at bit centres
module psf_ecu_rx (
    // clock and bit timing
    input  wire logic        i_mclk,
    input  int               i_bitc,
    // line from the framer
    input  wire logic        i_tx_data,
    input  wire logic        i_tx_active,
    // decoded frame
    output logic [63:0]      o_bits,
    output int               o_count,
    output int               o_frames
);
    timeunit 1ns;
    timeprecision 1ps;

    // ---------------------------------------------------------------
    // frame capture
    // ---------------------------------------------------------------
    // mid-bit sampling so the rounded bit count never lands on an edge
    initial begin
        o_bits = '0;
        o_count = 0;
        o_frames = 0;
        forever begin
            @(posedge i_tx_active);
            o_bits = '0;
            o_count = 0;
            repeat (i_bitc / 2) @(posedge i_mclk);
            while (i_tx_active === 1'b1) begin
                o_bits[o_count] = i_tx_data;
                o_count++;
                repeat (i_bitc) @(posedge i_mclk);
            end
            o_frames++;
        end
    end
endmodule : psf_ecu_rx

//--- tb/testbench.sv
// self-checking bench: axi4-lite setup and decoded psi5 frames
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    // ---------------------------------------------------------------
    // signals
    // ---------------------------------------------------------------
    logic        i_mclk, i_rst, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
    logic        i_sync, i_defect, i_init_ph3;
    logic [7:0]  i_awaddr, i_araddr;
    logic [31:0] i_wdata;
    logic [3:0]  i_wstrb;
    logic [23:0] i_position, i_speed;
    logic [5:0]  i_diag;
    logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
    logic        o_tx_data, o_tx_active, o_irq;
    logic [1:0]  o_bresp, o_rresp, rs;
    logic [31:0] o_rdata, rd;
    logic [2:0]  o_nibble_reps, crc;
    logic [63:0] rx_bits, ev;
    logic        par;
    int          rx_count, rx_frames, bitc, en;
    int          fail_count = 0;
    int          compares = 0;

    // 250 mhz clock
    always #2 i_mclk = ~i_mclk;

    // short periods keep the free-running gap small
    psf_framer #(.P_PER0_CYC(400), .P_PER1_CYC(400), .P_PER2_CYC(400), .P_PER3_CYC(400)) dut_u (
        .i_mclk(i_mclk), .i_rst(i_rst),
        .i_awvalid(i_awvalid), .o_awready(o_awready), .i_awaddr(i_awaddr),
        .i_wvalid(i_wvalid), .o_wready(o_wready), .i_wdata(i_wdata), .i_wstrb(i_wstrb),
        .o_bvalid(o_bvalid), .i_bready(i_bready), .o_bresp(o_bresp),
        .i_arvalid(i_arvalid), .o_arready(o_arready), .i_araddr(i_araddr),
        .o_rvalid(o_rvalid), .i_rready(i_rready), .o_rdata(o_rdata), .o_rresp(o_rresp),
        .i_sync(i_sync), .i_position(i_position), .i_speed(i_speed),
        .i_defect(i_defect), .i_diag(i_diag), .i_init_ph3(i_init_ph3),
        .o_tx_data(o_tx_data), .o_tx_active(o_tx_active),
        .o_nibble_reps(o_nibble_reps), .o_irq(o_irq));

    psf_ecu_rx ecu_u (.i_mclk(i_mclk), .i_bitc(bitc), .i_tx_data(o_tx_data),
        .i_tx_active(o_tx_active), .o_bits(rx_bits), .o_count(rx_count), .o_frames(rx_frames));

    // ---------------------------------------------------------------
    // tasks
    // ---------------------------------------------------------------
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got %0h exp %0h", $time, got, exp);
        end
    endtask : chk

    task automatic conclude;
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : conclude

    // address and data offered together, each dropped when taken
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_mclk);
        i_awvalid <= 1'b1;
        i_awaddr <= a;
        i_wvalid <= 1'b1;
        i_wdata <= d;
        i_bready <= 1'b1;
        for (int n = 0; n < 200; n++) begin
            @(posedge i_mclk);
            if (i_awvalid && o_awready) i_awvalid <= 1'b0;
            if (i_wvalid && o_wready) i_wvalid <= 1'b0;
            if (o_bvalid === 1'b1) begin
                rs = o_bresp;
                i_bready <= 1'b0;
                break;
            end
        end
    endtask : axw

    task automatic axr(input logic [7:0] a);
        @(posedge i_mclk);
        i_arvalid <= 1'b1;
        i_araddr <= a;
        i_rready <= 1'b1;
        for (int n = 0; n < 200; n++) begin
            @(posedge i_mclk);
            if (i_arvalid && o_arready) i_arvalid <= 1'b0;
            if (o_rvalid === 1'b1) begin
                rd = o_rdata;
                rs = o_rresp;
                i_rready <= 1'b0;
                break;
            end
        end
    endtask : axr

    // one expected line bit; checksum runs over the bits between the start pair and the checksum
    task automatic put(input logic b, input logic ck);
        logic fb;
        ev[en] = b;
        en++;
        if (ck) begin
            fb = b ^ crc[2];
            crc = {crc[1], crc[0] ^ fb, fb};
            par = par ^ b;
        end
    endtask : put

    task automatic mk(input logic st, input logic sv, input logic [23:0] d, input int w,
                      input logic pty);
        ev = '0;
        en = 0;
        crc = 3'h7;
        par = 1'b0;
        put(1'b0, 1'b0);
        put(1'b0, 1'b0);
        put(1'b1, 1'b1);
        put(1'b0, 1'b1);
        put(1'b0, 1'b1);
        if (st) put(sv, 1'b1);
        for (int i = 0; i < w; i++) put(d[i], 1'b1);
        if (pty) put(par, 1'b0);
        else begin
            put(crc[2], 1'b0);
            put(crc[1], 1'b0);
            put(crc[0], 1'b0);
        end
    endtask : mk

    task automatic wait_rx(input int t);
        for (int n = 0; n < 50000 && rx_frames < t; n++) @(posedge i_mclk);
    endtask : wait_rx

    task automatic pulse;
        @(posedge i_mclk);
        i_sync <= 1'b1;
        @(posedge i_mclk);
        i_sync <= 1'b0;
    endtask : pulse

    // ---------------------------------------------------------------
    // watchdog and main sequence
    // ---------------------------------------------------------------
    // both frames need about 70k cycles; cut off at 90k
    initial begin
        #360000;
        fail_count++;
        conclude();
    end

    initial begin
        {i_mclk, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, i_sync, i_defect} = '0;
        {i_awaddr, i_araddr, i_wdata, i_speed, i_init_ph3} = '0;
        i_rst = 1'b1;
        i_wstrb = 4'hf;
        i_position = 24'h0002a5;
        i_diag = 6'h25;
        bitc = 2000;                                  // 250 mhz over 125 kbps
        repeat (20) @(posedge i_mclk);
        i_rst <= 1'b0;
        axw(8'h08, 32'h00000001);
        axr(8'h00);
        chk(rd, 32'h00000001);
        axw(8'h00, 32'h00002001);
        axw(8'h10, 32'h00000000);
        chk(rs, 2'h2);
        axr(8'h10);
        chk({rs, rd}, {2'h2, 32'h00000000});
        wait_rx(1);
        mk(1'b0, 1'b0, 24'h0002a5, 10, 1'b0);
        chk(rx_bits, ev);
        chk(rx_count, en);
        chk(o_irq, 1'b1);
        axr(8'h04);
        chk(rd, 32'h00000001);
        @(posedge i_mclk);
        chk(o_irq, 1'b0);
        axw(8'h08, 32'h00000004);
        // sixteen-bit payload, parity, 189 kbps, error status
        axw(8'h00, 32'h00007637);
        axr(8'h00);
        chk(rd, 32'h00007637);
        chk(o_nibble_reps, 3'h4);
        bitc = 1322;                                  // 250 mhz over 189 kbps, rounded down
        i_defect <= 1'b1;
        chk(rx_frames, 1);
        pulse();
        repeat (50) @(posedge i_mclk);
        chk(o_tx_active, 1'b1);
        chk(o_irq, 1'b0);
        pulse();
        repeat (2) @(posedge i_mclk);
        chk(o_irq, 1'b1);
        wait_rx(2);
        mk(1'b1, 1'b1, 24'h007d25, 16, 1'b1);
        chk(rx_bits, ev);
        chk(rx_count, en);
        axr(8'h04);
        chk(rd, 32'h00000007);
        axr(8'h0c);
        chk(rd, 32'h00007d25);
        // init phase three defect word, read back as soon as it is loaded
        i_init_ph3 <= 1'b1;
        pulse();
        repeat (2) @(posedge i_mclk);
        axr(8'h0c);
        chk(rd, 32'h000001f4);
        conclude();
    end
endmodule : testbench
